// File: verilog/rcfs_rx_checksum_filter_status.sv
`timescale 1ns/1ps
module rcfs_rx_checksum_filter_status
    import rcfs_pkg::*;
#(
    parameter int RX_STATUS_DEPTH = 16,
    parameter logic [12:0] TX_QUEUE_BYTES = RCFS_TX_QUEUE_BYTES
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    input wire logic udp_checksum_check_enable,
    input wire logic [47:0] station_addr,
    input wire logic rx_frame_done,
    input wire rcfs_frame_info_t rx_frame_info,
    output logic rx_frame_accept,
    output logic rx_frame_drop,
    output logic rx_status_overflow,
    input wire logic rx_status_pop,
    output logic [$clog2(RX_STATUS_DEPTH+1)-1:0] rx_frame_count,
    output logic tx_udp_lite_insert,
    input wire logic tx_alloc,
    input wire logic [12:0] tx_alloc_bytes,
    input wire logic tx_release,
    input wire logic [12:0] tx_release_bytes
);
    localparam int PW = $clog2(RX_STATUS_DEPTH);
    localparam int CW = $clog2(RX_STATUS_DEPTH+1);
    localparam logic [CW-1:0] DEPTH_C = CW'(RX_STATUS_DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);

    logic [4:0] ctrl_reg, ctrl_next;
    logic [12:0] free_reg, free_next;
    logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [CW-1:0] count_reg, count_next;
    logic [15:0] rdata_next;
    rcfs_status_t status_mem [RX_STATUS_DEPTH];
    rcfs_status_t head_status, head_shown;
    rcfs_cfg_t cfg;
    logic wr_ctrl, sel_ctrl, sel_free, sel_stat;
    logic v_valid, v_drop;
    rcfs_status_t v_status;
    logic push, pop, full, empty;
    logic [15:0] ctrl_word, free_word, stat_word;
    logic [13:0] free_sum;

    // Address decode; only the control register takes writes
    assign sel_ctrl = host_addr == RCFS_RX_CTRL2_OFF;
    assign sel_free = host_addr == RCFS_TX_FREE_OFF;
    assign sel_stat = host_addr == RCFS_RX_HDR_STAT_OFF;
    assign wr_ctrl = host_wr & sel_ctrl;
    assign ctrl_next = wr_ctrl ? host_wdata[4:0] : ctrl_reg;

    // Control fields steer the frame filter
    assign cfg.udp_fragment_checksum_pass = ctrl_reg[RCFS_FRAG_PASS_BIT];
    assign cfg.udp_zero_checksum_accept = ctrl_reg[RCFS_ZERO_ACCEPT_BIT];
    assign cfg.udp_lite_checksum_enable = ctrl_reg[RCFS_LITE_EN_BIT];
    assign cfg.icmp_checksum_check_enable = ctrl_reg[RCFS_ICMP_EN_BIT];
    assign cfg.source_address_self_filter = ctrl_reg[RCFS_SAF_BIT];
    assign cfg.udp_checksum_check_enable = udp_checksum_check_enable;
    assign tx_udp_lite_insert = ctrl_reg[RCFS_LITE_EN_BIT];

    rcfs_frame_filter u_filter (
        .core_clk(core_clk),
        .reset(reset),
        .cfg(cfg),
        .station_addr(station_addr),
        .frame_done(rx_frame_done),
        .info(rx_frame_info),
        .verdict_valid(v_valid),
        .verdict_drop(v_drop),
        .verdict_status(v_status)
    );

    // Status store: only kept frames enter, so the head entry is always complete
    assign full = count_reg == DEPTH_C;
    assign empty = count_reg == '0;
    assign push = v_valid & ~v_drop & ~full;
    assign pop = rx_status_pop & ~empty;
    assign count_next = count_reg + (push ? ONE_C : '0) - (pop ? ONE_C : '0);
    assign head_status = status_mem[rd_ptr_reg];
    assign rx_frame_count = count_reg;

    // Free space: allocation charges the control word too, release returns the total
    assign free_sum = {1'b0, free_reg}
                      - (tx_alloc ? {1'b0, tx_alloc_bytes + RCFS_TX_CTRL_WORD_BYTES} : 14'h0000)
                      + (tx_release ? {1'b0, tx_release_bytes} : 14'h0000);
    assign free_next = free_sum[12:0];

    // Read words; reserved positions are tied to zero
    assign ctrl_word = {11'h000, ctrl_reg};
    assign free_word = {3'h0, free_reg};
    // Entries carry no reset, so an empty store must mask its stale head slot
    assign head_shown = empty ? '0 : head_status;
    assign stat_word = {~empty, 1'b0, head_shown, 10'h000};
    assign rdata_next = !host_rd ? host_rdata
                      : sel_ctrl ? ctrl_word
                      : sel_free ? free_word
                      : sel_stat ? stat_word
                      : 16'h0000;

    // Register state; a read only loads the read-data latch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg <= RCFS_RX_CTRL2_RESET;
            free_reg <= TX_QUEUE_BYTES;
            host_rdata <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            free_reg <= free_next;
            host_rdata <= rdata_next;
        end
    end

    // Status store pointers and occupancy
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(RX_STATUS_DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(RX_STATUS_DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Entry storage has no reset; empty store hides stale contents
    always_ff @(posedge core_clk) begin
        if (push) begin
            status_mem[wr_ptr_reg] <= v_status;
        end
    end

    // Verdict pulses; a full store loses the frame and says so
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_frame_accept <= 1'b0;
            rx_frame_drop <= 1'b0;
            rx_status_overflow <= 1'b0;
        end else begin
            rx_frame_accept <= push;
            rx_frame_drop <= v_valid & v_drop;
            rx_status_overflow <= v_valid & ~v_drop & full;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_alloc_only;
        tx_alloc && !tx_release;
    endsequence

    sequence s_charged;
        free_reg == 13'($past(free_reg) - $past(tx_alloc_bytes) - RCFS_TX_CTRL_WORD_BYTES);
    endsequence

    a_tx_deduct: assert property (s_alloc_only |=> s_charged)
        else $error("free count not charged with control word");
    a_free_hold: assert property (!tx_alloc && !tx_release |=> $stable(free_reg))
        else $error("free count moved without traffic");
    a_valid_flag: assert property (host_rd && sel_stat
        |=> host_rdata[RCFS_VALID_BIT] == ($past(count_reg) != '0))
        else $error("frame valid flag wrong");
    a_empty_low: assert property (empty && !push ##1 host_rd && sel_stat
        |=> !host_rdata[RCFS_VALID_BIT]) else $error("frame valid set while empty");
    a_empty_flags: assert property (host_rd && sel_stat && empty
        |=> host_rdata[13:10] == 4'h0) else $error("stale flags shown while empty");
    a_ctrl_write: assert property (wr_ctrl |=> ctrl_reg == $past(host_wdata[4:0]))
        else $error("control write lost");
    a_read_quiet: assert property (host_rd && !host_wr |=> $stable(ctrl_reg))
        else $error("read changed control");
    a_reserved_zero: assert property (host_rd && sel_free |=> host_rdata[15:13] == 3'h0)
        else $error("reserved bits not zero");
    a_accept_count: assert property (v_valid && !v_drop && !full && !pop
        |=> count_reg == $past(count_reg) + ONE_C) else $error("kept frame not counted");
    a_unmapped_zero: assert property (host_rd && !sel_ctrl && !sel_free && !sel_stat
        |=> host_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule : rcfs_rx_checksum_filter_status

// File: shared/rcfs_pkg.sv
package rcfs_pkg;
    // Register byte addresses on the parallel host interface
    localparam logic [7:0] RCFS_RX_CTRL2_OFF = 8'h76;
    localparam logic [7:0] RCFS_TX_FREE_OFF = 8'h78;
    localparam logic [7:0] RCFS_RX_HDR_STAT_OFF = 8'h7c;

    // Field positions of receive_control_two
    localparam int RCFS_FRAG_PASS_BIT = 4;
    localparam int RCFS_ZERO_ACCEPT_BIT = 3;
    localparam int RCFS_LITE_EN_BIT = 2;
    localparam int RCFS_ICMP_EN_BIT = 1;
    localparam int RCFS_SAF_BIT = 0;
    localparam logic [4:0] RCFS_RX_CTRL2_RESET = 5'h00;

    // Field positions of rx_frame_header_status
    localparam int RCFS_VALID_BIT = 15;
    localparam int RCFS_ICMP_ERR_BIT = 13;
    localparam int RCFS_IP_ERR_BIT = 12;
    localparam int RCFS_TCP_ERR_BIT = 11;
    localparam int RCFS_UDP_ERR_BIT = 10;

    // Transmit queue accounting
    localparam int RCFS_TX_FREE_W = 13;
    localparam logic [12:0] RCFS_TX_CTRL_WORD_BYTES = 13'h0004;
    localparam logic [12:0] RCFS_TX_QUEUE_BYTES = 13'h1800;

    // Checksum and filter controls, register bits plus the receive-one check enable
    typedef struct packed {
        logic udp_fragment_checksum_pass;
        logic udp_zero_checksum_accept;
        logic udp_lite_checksum_enable;
        logic icmp_checksum_check_enable;
        logic source_address_self_filter;
        logic udp_checksum_check_enable;
    } rcfs_cfg_t;

    // Classification of one completed received frame from the parser
    typedef struct packed {
        logic is_udp;
        logic is_udp_lite;
        logic is_tcp;
        logic is_icmp;
        logic is_fragment;
        logic udp_csum_zero;
        logic udp_csum_bad;
        logic tcp_csum_bad;
        logic icmp_csum_bad;
        logic ip_csum_bad;
        logic [47:0] src_addr;
    } rcfs_frame_info_t;

    // Per-frame error flags kept in the status store
    typedef struct packed {
        logic icmp_checksum_error_flag;
        logic ip_header_checksum_error_flag;
        logic tcp_checksum_error_flag;
        logic udp_checksum_error_flag;
    } rcfs_status_t;
endpackage : rcfs_pkg

// File: verilog/rcfs_frame_filter.sv
`timescale 1ns/1ps
module rcfs_frame_filter
    import rcfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire rcfs_cfg_t cfg,
    input wire logic [47:0] station_addr,
    input wire logic frame_done,
    input wire rcfs_frame_info_t info,
    output logic verdict_valid,
    output logic verdict_drop,
    output rcfs_status_t verdict_status
);
    logic sa_match, frag_skip, zero_drop, udp_drop, lite_drop, icmp_drop, drop_any;
    rcfs_status_t status_now;

    // Fragment pass exempts fragmented UDP and UDP-Lite checksum checks; fragmented ICMP is never checked
    assign sa_match = info.src_addr == station_addr;
    assign frag_skip = cfg.udp_fragment_checksum_pass & info.is_fragment;
    assign zero_drop = info.is_udp & info.udp_csum_zero & ~cfg.udp_zero_checksum_accept;
    assign udp_drop = info.is_udp & ~info.udp_csum_zero & info.udp_csum_bad
                      & cfg.udp_checksum_check_enable & ~frag_skip;
    // UDP-Lite is only verified when enabled; disabled means it always passes
    assign lite_drop = info.is_udp_lite & info.udp_csum_bad & cfg.udp_lite_checksum_enable
                       & ~frag_skip;
    assign icmp_drop = info.is_icmp & ~info.is_fragment & info.icmp_csum_bad
                       & cfg.icmp_checksum_check_enable;
    assign drop_any = (cfg.source_address_self_filter & sa_match)
                      | zero_drop | udp_drop | lite_drop | icmp_drop;

    // Error flags are reported for kept frames even when checking is off, except UDP-Lite, flagged only when enabled
    assign status_now.icmp_checksum_error_flag = info.is_icmp & info.icmp_csum_bad;
    assign status_now.ip_header_checksum_error_flag = info.ip_csum_bad;
    assign status_now.tcp_checksum_error_flag = info.is_tcp & info.tcp_csum_bad;
    assign status_now.udp_checksum_error_flag = (info.is_udp & info.udp_csum_bad)
        | (info.is_udp_lite & info.udp_csum_bad & cfg.udp_lite_checksum_enable);

    // One-cycle registered verdict per completed frame
    always_ff @(posedge core_clk) begin
        if (reset) begin
            verdict_valid <= 1'b0;
            verdict_drop <= 1'b0;
            verdict_status <= '0;
        end else begin
            verdict_valid <= frame_done;
            verdict_drop <= frame_done & drop_any;
            if (frame_done) begin
                verdict_status <= status_now;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_sa_drop: assert property (frame_done && cfg.source_address_self_filter && sa_match
        |=> verdict_valid && verdict_drop) else $error("own source address not dropped");
    a_zero_drop: assert property (frame_done && info.is_udp && info.udp_csum_zero
        |=> verdict_drop || $past(cfg.udp_zero_checksum_accept))
        else $error("zero udp checksum not dropped");
    a_frag_pass: assert property (frame_done && info.is_udp && !info.udp_csum_zero
        && info.is_fragment && cfg.udp_fragment_checksum_pass && !sa_match
        |=> !verdict_drop) else $error("fragment udp frame dropped");
    a_lite_pass: assert property (frame_done && info.is_udp_lite && !info.is_udp
        && !info.is_icmp && !cfg.udp_lite_checksum_enable && !sa_match
        |=> !verdict_drop) else $error("udp lite dropped while disabled");
    a_icmp_drop: assert property (frame_done && info.is_icmp && !info.is_fragment
        && info.icmp_csum_bad && cfg.icmp_checksum_check_enable
        |=> verdict_drop) else $error("bad icmp frame kept");
    a_ip_flag: assert property (frame_done
        |=> verdict_status.ip_header_checksum_error_flag == $past(info.ip_csum_bad))
        else $error("ip checksum flag wrong");
    a_drop_needs_valid: assert property (verdict_drop |-> verdict_valid)
        else $error("drop without verdict");
endmodule : rcfs_frame_filter

// File: tb/rcfs_host_model.sv
`timescale 1ns/1ps
// Host processor on the register interface; each access holds its strobe one edge
module rcfs_host_model
    import rcfs_pkg::*;
(
    input wire logic core_clk,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    output logic tx_alloc,
    output logic [12:0] tx_alloc_bytes
);
    // Idle levels from time zero
    initial begin
        host_wr = 1'h0;
        host_rd = 1'h0;
        host_addr = 8'h00;
        host_wdata = 16'h0000;
        tx_alloc = 1'h0;
        tx_alloc_bytes = 13'h0000;
    end

    // Strobe rises after an edge, drops after the edge that takes it
    task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        #1;
        host_addr = addr;
        host_wdata = data;
        host_wr = 1'h1;
        @(posedge core_clk);
        #1;
        host_wr = 1'h0;
    endtask : reg_write

    // Read data is registered, so it is settled just after the taking edge
    task automatic reg_read(input logic [7:0] addr, output logic [15:0] data);
        @(posedge core_clk);
        #1;
        host_addr = addr;
        host_rd = 1'h1;
        @(posedge core_clk);
        #1;
        host_rd = 1'h0;
        data = host_rdata;
    endtask : reg_read

    // Free space is read first so a frame is never started without room for it
    task automatic tx_reserve(input logic [12:0] bytes, output logic ok);
        logic [15:0] free;
        reg_read(RCFS_TX_FREE_OFF, free);
        ok = (free[12:0] >= bytes + RCFS_TX_CTRL_WORD_BYTES);
        if (ok) begin
            @(posedge core_clk);
            #1;
            tx_alloc_bytes = bytes;
            tx_alloc = 1'h1;
            @(posedge core_clk);
            #1;
            tx_alloc = 1'h0;
        end
    endtask : tx_reserve
endmodule : rcfs_host_model

// File: tb/rcfs_rx_checksum_filter_status_tb.sv
`timescale 1ns/1ps
module rcfs_rx_checksum_filter_status_tb
    import rcfs_pkg::*;
;
    localparam int DEPTH = 4;
    localparam logic [12:0] QBYTES = 13'h0100;
    localparam logic [47:0] STATION = 48'h02a0_b1c2_d3e4;
    logic core_clk, reset, host_wr, host_rd, ucce, frame_done, acc, drp, ovf, pop_q;
    logic lite_ins, tx_alloc, tx_release, ok;
    logic [7:0] host_addr;
    logic [15:0] host_wdata, host_rdata, rd;
    logic [12:0] alloc_bytes, release_bytes;
    logic [$clog2(DEPTH+1)-1:0] count;
    rcfs_frame_info_t info;
    int failures = 0;
    int comparisons = 0;

    // Free-running 200 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end

    rcfs_rx_checksum_filter_status #(.RX_STATUS_DEPTH(DEPTH), .TX_QUEUE_BYTES(QBYTES)) dut (
        .core_clk(core_clk), .reset(reset), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .udp_checksum_check_enable(ucce), .station_addr(STATION),
        .rx_frame_done(frame_done), .rx_frame_info(info), .rx_frame_accept(acc),
        .rx_frame_drop(drp), .rx_status_overflow(ovf), .rx_status_pop(pop_q),
        .rx_frame_count(count), .tx_udp_lite_insert(lite_ins), .tx_alloc(tx_alloc),
        .tx_alloc_bytes(alloc_bytes), .tx_release(tx_release),
        .tx_release_bytes(release_bytes));

    rcfs_host_model host (
        .core_clk(core_clk), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .tx_alloc(tx_alloc),
        .tx_alloc_bytes(alloc_bytes));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Verdict stands only in the cycle after the edge that follows the done pulse
    task automatic send_frame(input logic [9:0] kind, input logic same, input logic a,
        input logic d, input logic o);
        @(posedge core_clk);
        #1;
        info = rcfs_frame_info_t'({kind, same ? STATION : ~STATION});
        frame_done = 1'h1;
        @(posedge core_clk);
        #1;
        frame_done = 1'h0;
        @(posedge core_clk);
        #1;
        check("accept", 16'(acc), 16'(a));
        check("drop", 16'(drp), 16'(d));
        check("overflow", 16'(ovf), 16'(o));
    endtask : send_frame

    task automatic pop_head();
        @(posedge core_clk);
        #1;
        pop_q = 1'h1;
        @(posedge core_clk);
        #1;
        pop_q = 1'h0;
    endtask : pop_head

    // One frame under one setting; a kept frame's status is read twice, then released
    task automatic run_case(input logic [4:0] ctrl, input logic uce, input logic [9:0] kind,
        input logic same, input logic d, input logic [3:0] st);
        logic [15:0] v;
        host.reg_write(RCFS_RX_CTRL2_OFF, {11'h000, ctrl});
        ucce = uce;
        check("lite_insert", 16'(lite_ins), 16'(ctrl[2]));
        send_frame(kind, same, !d, d, 1'h0);
        if (!d) begin
            repeat (2) begin
                host.reg_read(RCFS_RX_HDR_STAT_OFF, v);
                check("head_status", v, {2'h2, st, 10'h000});
            end
            pop_head();
            host.reg_read(RCFS_RX_HDR_STAT_OFF, v);
            check("status_empty", v, 16'h0000);
        end
    endtask : run_case

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    // Kind bits: udp lite tcp icmp frag zero udpbad tcpbad icmpbad ipbad
    initial begin
        reset = 1'h1;
        ucce = 1'h0;
        frame_done = 1'h0;
        info = '0;
        pop_q = 1'h0;
        tx_release = 1'h0;
        release_bytes = 13'h0000;
        repeat (5) @(posedge core_clk);
        #1;
        reset = 1'h0;
        host.reg_read(RCFS_RX_CTRL2_OFF, rd);
        check("ctrl_reset", rd, 16'h0000);
        host.reg_read(RCFS_TX_FREE_OFF, rd);
        check("free_reset", rd, {3'h0, QBYTES});
        host.reg_read(RCFS_RX_HDR_STAT_OFF, rd);
        check("status_reset", rd, 16'h0000);
        host.reg_read(8'h7a, rd);
        check("unmapped", rd, 16'h0000);
        host.reg_write(RCFS_RX_CTRL2_OFF, 16'hffff);
        host.reg_read(RCFS_RX_CTRL2_OFF, rd);
        check("ctrl_mask", rd, 16'h001f);
        host.reg_write(RCFS_TX_FREE_OFF, 16'h0000);
        host.reg_read(RCFS_TX_FREE_OFF, rd);
        check("free_ro", rd, {3'h0, QBYTES});
        run_case(5'h01, 1'h0, 10'h080, 1'h1, 1'h1, 4'h0);
        run_case(5'h00, 1'h0, 10'h080, 1'h1, 1'h0, 4'h0);
        run_case(5'h00, 1'h0, 10'h210, 1'h0, 1'h1, 4'h0);
        run_case(5'h08, 1'h0, 10'h210, 1'h0, 1'h0, 4'h0);
        run_case(5'h00, 1'h1, 10'h208, 1'h0, 1'h1, 4'h0);
        run_case(5'h10, 1'h1, 10'h228, 1'h0, 1'h0, 4'h1);
        run_case(5'h00, 1'h1, 10'h228, 1'h0, 1'h1, 4'h0);
        run_case(5'h04, 1'h0, 10'h108, 1'h0, 1'h1, 4'h0);
        run_case(5'h00, 1'h0, 10'h108, 1'h0, 1'h0, 4'h0);
        run_case(5'h02, 1'h0, 10'h042, 1'h0, 1'h1, 4'h0);
        run_case(5'h02, 1'h0, 10'h062, 1'h0, 1'h0, 4'h8);
        run_case(5'h00, 1'h0, 10'h084, 1'h0, 1'h0, 4'h2);
        run_case(5'h00, 1'h0, 10'h081, 1'h0, 1'h0, 4'h4);
        // Store holds DEPTH frames; the next kept frame is lost
        for (int i = 0; i <= DEPTH; i++) begin
            send_frame(10'h080, 1'h0, i < DEPTH, 1'h0, i == DEPTH);
        end
        check("frame_count", 16'(count), 16'(DEPTH));
        for (int i = 0; i < DEPTH; i++) begin
            host.reg_read(RCFS_RX_HDR_STAT_OFF, rd);
            check("queued_status", rd, 16'h8000);
            pop_head();
        end
        host.reg_read(RCFS_RX_HDR_STAT_OFF, rd);
        check("drained_status", rd, 16'h0000);
        // Transmit space: payload plus control word out, all of it back
        host.tx_reserve(13'h0040, ok);
        check("reserve_ok", 16'(ok), 16'h0001);
        host.reg_read(RCFS_TX_FREE_OFF, rd);
        check("free_after_alloc", rd, {3'h0, QBYTES - 13'h0044});
        @(posedge core_clk);
        #1;
        tx_release = 1'h1;
        release_bytes = 13'h0044;
        @(posedge core_clk);
        #1;
        tx_release = 1'h0;
        host.reg_read(RCFS_TX_FREE_OFF, rd);
        check("free_after_release", rd, {3'h0, QBYTES});
        tally_and_finish();
    end
endmodule : rcfs_rx_checksum_filter_status_tb
